/* hdl/bus_master.sv */
// Purpose: two-wire master end driving the memory link
// Assumes: one command at a time; length 1 to 4 bytes
// Notes:   waits the longest write time instead of polling
`include "eeprom_cfg.svh"
module bus_master import eeprom_pkg::*; #(
    parameter int QTR_CYC  = `SCL_QTR_CYC,
    parameter int PUR_CYC  = `MS_TO_CYC(`PUR_MS),
    parameter int PUW_CYC  = `MS_TO_CYC(`PUW_MS),
    parameter int WAIT_CYC = `MS_TO_CYC(`WR_MAX_MS)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    two_wire_if.mst          bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [6:0]  cmd_addr,
    input  wire logic [2:0]  cmd_len,
    input  wire logic [31:0] cmd_wdata,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    output logic             done,
    output logic             nack
);
    localparam int QW = $clog2(QTR_CYC + 1);
    localparam int PW = $clog2(PUW_CYC + 1);
    localparam int WW = $clog2(WAIT_CYC + 1);
    if (QTR_CYC < 1 || PUR_CYC > PUW_CYC || WAIT_CYC < 1) begin : g_chk
        $error("bus_master timing parameters out of range");
    end

    mst_state_t  st_q;
    logic [QW-1:0] qdiv_q;
    logic [1:0]  qph_q;
    logic [3:0]  bit_q;
    logic [2:0]  byte_q;
    logic [2:0]  len_q;
    logic [7:0]  sh_q;
    logic [31:0] wdata_q;
    logic        read_q;
    logic        ackbad_q;
    logic        scl_q;
    logic        oe_n_q;
    logic [PW-1:0] pu_q;
    logic [WW-1:0] wait_q;
    logic        sda_f;

    line_filter u_sda_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (bus.sda),
        .filt  (sda_f)
    );

    wire tick    = (qdiv_q == QW'(QTR_CYC - 1));
    wire tx      = (byte_q == 3'h0) | ~read_q;
    wire last    = (byte_q == len_q);
    wire pu_rd   = (pu_q >= PW'(PUR_CYC));
    wire pu_wr   = (pu_q == PW'(PUW_CYC));
    wire [7:0] nxt_w = wdata_q[{byte_q[1:0], 3'h0} +: 8];

    assign cmd_ready        = (st_q == M_IDLE) & (cmd_read ? pu_rd : pu_wr);
    assign bus.scl          = scl_q;
    assign bus.mst_sda_o    = 1'b0;
    assign bus.mst_sda_oe_n = oe_n_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            qdiv_q <= '0;
            pu_q   <= '0;
        end else begin
            qdiv_q <= tick ? '0 : qdiv_q + QW'(1);
            pu_q   <= pu_wr ? pu_q : pu_q + PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= M_IDLE;
            qph_q <= '0;
            bit_q <= '0;
            byte_q <= '0;
            len_q <= '0;
            sh_q <= '0;
            wdata_q <= '0;
            read_q <= 1'b0;
            ackbad_q <= 1'b0;
            scl_q <= 1'b1;
            oe_n_q <= 1'b1;
            wait_q <= '0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            done <= 1'b0;
            nack <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done     <= 1'b0;
            if (st_q == M_IDLE) begin
                if (cmd_valid && cmd_ready) begin
                    st_q    <= M_START;
                    qph_q   <= '0;
                    read_q  <= cmd_read;
                    len_q   <= cmd_len;
                    wdata_q <= cmd_wdata;
                    sh_q    <= {cmd_addr, cmd_read};
                    nack    <= 1'b0;
                end
            end else if (st_q == M_WAIT) begin
                wait_q <= wait_q - WW'(1);
                if (wait_q == WW'(1)) begin
                    st_q <= M_IDLE;
                end
            end else if (tick) begin
                qph_q <= qph_q + 2'h1;
                case (st_q)
                    M_START: begin
                        if (qph_q == 2'h0) begin
                            scl_q  <= 1'b1;
                            oe_n_q <= 1'b1;
                        end else if (qph_q == 2'h2) begin
                            oe_n_q <= 1'b0;
                        end else if (qph_q == 2'h3) begin
                            scl_q  <= 1'b0;
                            st_q   <= M_BIT;
                            bit_q  <= '0;
                            byte_q <= '0;
                        end
                    end
                    M_BIT: begin
                        if (qph_q == 2'h0) begin
                            if (bit_q != `BYTE_DONE) begin
                                oe_n_q <= ~tx | sh_q[7];
                            end else begin
                                oe_n_q <= tx | last;
                            end
                        end else if (qph_q == 2'h1) begin
                            scl_q <= 1'b1;
                        end else if (qph_q == 2'h2) begin
                            if (bit_q != `BYTE_DONE && !tx) begin
                                sh_q <= {sh_q[6:0], sda_f};
                            end
                            if (bit_q == `BYTE_DONE && tx) begin
                                ackbad_q <= sda_f;
                            end
                        end else begin
                            scl_q <= 1'b0;
                            if (bit_q != `BYTE_DONE) begin
                                bit_q <= bit_q + 4'h1;
                                if (tx) begin
                                    sh_q <= {sh_q[6:0], 1'b0};
                                end
                            end else begin
                                bit_q <= '0;
                                if (!tx) begin
                                    rd_valid <= 1'b1;
                                    rd_data  <= sh_q;
                                end
                                if (tx && ackbad_q) begin
                                    nack <= 1'b1;
                                    st_q <= M_STOP;
                                end else if (last) begin
                                    st_q <= M_STOP;
                                end else begin
                                    byte_q <= byte_q + 3'h1;
                                    sh_q   <= nxt_w;
                                end
                            end
                        end
                    end
                    M_STOP: begin
                        if (qph_q == 2'h0) begin
                            oe_n_q <= 1'b0;
                        end else if (qph_q == 2'h1) begin
                            scl_q <= 1'b1;
                        end else if (qph_q == 2'h2) begin
                            oe_n_q <= 1'b1;
                        end else begin
                            done <= 1'b1;
                            if (!read_q && !nack) begin
                                st_q   <= M_WAIT;
                                wait_q <= WW'(WAIT_CYC);
                            end else begin
                                st_q <= M_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_q <= M_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* hdl/eeprom_slave.sv */
// Purpose: slave end of a 128 x 8 two-wire nonvolatile memory
// Assumes: master drives clock; data line is open-drain with pull-up
// Notes:   write cycle length is a parameter so benches can shorten it
`include "eeprom_cfg.svh"
// Summary of operation
// - Data changes only while clock low
// - Start is data fall, clock high
// - Master ends transfers with stop
// - Stop after read returns to standby
// - Stop only after transmitter releases data
// - Release after eight bits; receiver acks ninth
// - Take address plus direction, then acknowledge
// - Acknowledge every written data byte
// - Stop after write launches timed cycle
// - Bus ignored during write cycle
// - Never pull data low while writing
// - Master waits maximum write time
// - Master clocks; device is always slave
// - Filter pulses under 100 ns
// - Master waits power-up delays
// - Array holds 128 bytes
// - Data output is open-drain
// - Page write up to four bytes
// - Page address wraps in low two bits
// - Direction one reads, zero writes
// - Keep sending while master acknowledges
// - Read address wraps 127 to 0
module eeprom_slave import eeprom_pkg::*; #(
    parameter int WR_CYCLES = `MS_TO_CYC(`WR_TYP_MS)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    two_wire_if.dev   bus,
    output logic      write_busy,
    output logic      standby
);
    localparam int WW = $clog2(WR_CYCLES + 1);
    if (WR_CYCLES < 1 || WR_CYCLES > `MS_TO_CYC(`WR_MAX_MS)) begin : g_chk
        $error("WR_CYCLES outside the allowed write cycle time");
    end

    slv_state_t  st_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic [6:0]  addr_q;
    logic        rw_q;
    logic        nack_q;
    logic        oe_n_q;
    logic [3:0]  pvalid_q;
    logic        busy_q;
    logic [WW-1:0] wr_cnt_q;
    logic        scl_p_q;
    logic        sda_p_q;
    logic [7:0]  mem_q  [0:`WORDS-1];
    logic [7:0]  page_q [0:`PAGE_BYTES-1];
    logic        scl_f;
    logic        sda_f;

    line_filter u_scl_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (bus.scl),
        .filt  (scl_f)
    );
    line_filter u_sda_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (bus.sda),
        .filt  (sda_f)
    );

    // Conditions only from filtered lines, so clock glitches cannot fake them
    wire scl_rise  = scl_f & ~scl_p_q;
    wire scl_fall  = ~scl_f & scl_p_q;
    wire start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
    wire stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    wire in_write  = (st_q == S_WDATA) || (st_q == S_WACK);
    wire launch    = stop_det & in_write & (|pvalid_q) & ~busy_q;
    wire commit    = busy_q & (wr_cnt_q == WW'(1));
    wire byte_in   = (cnt_q == `BYTE_DONE);
    wire page_wr   = (st_q == S_WDATA) & scl_fall & byte_in;
    wire [7:0] rd_byte = mem_q[addr_q];

    // Only low or released: the high level comes from the pull-up
    assign bus.dev_sda_o    = 1'b0;
    assign bus.dev_sda_oe_n = oe_n_q | busy_q;
    assign write_busy       = busy_q;
    assign standby          = (st_q == S_IDLE) & ~busy_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            wr_cnt_q <= '0;
        end else if (launch) begin
            busy_q   <= 1'b1;
            wr_cnt_q <= WW'(WR_CYCLES);
        end else if (busy_q) begin
            busy_q   <= ~commit;
            wr_cnt_q <= wr_cnt_q - WW'(1);
        end
    end

    // Array has no reset; the received page bytes land at end of the write cycle
    always_ff @(posedge clk) begin
        if (page_wr) begin
            page_q[addr_q[1:0]] <= sh_q;
        end
        if (commit) begin
            for (int i = 0; i < `PAGE_BYTES; i++) begin
                if (pvalid_q[i]) begin
                    mem_q[{addr_q[6:2], 2'(i)}] <= page_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q     <= S_IDLE;
            cnt_q    <= '0;
            sh_q     <= '0;
            addr_q   <= '0;
            rw_q     <= 1'b0;
            nack_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            pvalid_q <= '0;
        end else if (start_det) begin
            st_q   <= S_ADDR;
            cnt_q  <= '0;
            oe_n_q <= 1'b1;
        end else if (stop_det) begin
            st_q   <= S_IDLE;
            oe_n_q <= 1'b1;
        end else if (scl_rise) begin
            case (st_q)
                S_ADDR, S_WDATA: begin
                    if (!byte_in) begin
                        sh_q  <= {sh_q[6:0], sda_f};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                S_RACK: begin
                    nack_q <= sda_f;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_q)
                S_ADDR: begin
                    if (byte_in) begin
                        cnt_q <= '0;
                        if (busy_q) begin
                            st_q <= S_IDLE;
                        end else begin
                            addr_q   <= sh_q[7:1];
                            rw_q     <= sh_q[0];
                            pvalid_q <= '0;
                            oe_n_q   <= 1'b0;
                            st_q     <= S_AACK;
                        end
                    end
                end
                S_AACK: begin
                    if (rw_q == `RW_READ) begin
                        st_q   <= S_RDATA;
                        sh_q   <= rd_byte;
                        oe_n_q <= rd_byte[7];
                        cnt_q  <= 4'h1;
                    end else begin
                        st_q   <= S_WDATA;
                        oe_n_q <= 1'b1;
                        cnt_q  <= '0;
                    end
                end
                S_WDATA: begin
                    if (byte_in) begin
                        pvalid_q[addr_q[1:0]] <= 1'b1;
                        addr_q <= {addr_q[6:2], addr_q[1:0] + 2'h1};
                        oe_n_q <= 1'b0;
                        st_q   <= S_WACK;
                    end
                end
                S_WACK: begin
                    oe_n_q <= 1'b1;
                    cnt_q  <= '0;
                    st_q   <= S_WDATA;
                end
                S_RDATA: begin
                    if (byte_in) begin
                        oe_n_q <= 1'b1;
                        addr_q <= addr_q + 7'h1;
                        st_q   <= S_RACK;
                    end else begin
                        oe_n_q <= sh_q[6];
                        sh_q   <= {sh_q[6:0], 1'b0};
                        cnt_q  <= cnt_q + 4'h1;
                    end
                end
                S_RACK: begin
                    if (!nack_q) begin
                        st_q   <= S_RDATA;
                        sh_q   <= rd_byte;
                        oe_n_q <= rd_byte[7];
                        cnt_q  <= 4'h1;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
        // Kept out of the edge chain so a commit never swallows a clock edge
        if (commit) begin
            pvalid_q <= '0;
        end
    end
endmodule

/* hdl/line_filter.sv */
// Purpose: synchronise a pin and drop short pulses
// Assumes: line idles high
// Notes:   adds two plus STABLE_CYC cycles of delay
`include "eeprom_cfg.svh"
module line_filter #(
    parameter int STABLE_CYC = `FILT_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      filt
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    if (STABLE_CYC < 1) begin : g_chk
        $error("STABLE_CYC must be at least 1");
    end
    logic          meta_q;
    logic          sync_q;
    logic [CW-1:0] cnt_q;
    wire           settled = (cnt_q == CW'(STABLE_CYC - 1));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            filt   <= 1'b1;
            cnt_q  <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
            if (sync_q == filt) begin
                cnt_q <= '0;
            end else if (settled) begin
                filt  <= sync_q;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end
endmodule

/* inc/eeprom_cfg.svh */
// Purpose: timing, width and field constants for the two-wire memory link
// Assumes: 40 MHz system clock
// Notes:   counts derive from printed times; least times round up
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define CLK_NS          25
`define FILT_NS         100
`define FILT_CYC        ((`FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_TYP_MS       5
`define WR_MAX_MS       10
`define PUR_MS          1
`define PUW_MS          5
`define MS_TO_CYC(m)    (((m) * 1000000) / `CLK_NS)
`define SCL_KHZ         100
`define SCL_QTR_NS      (1000000 / (4 * `SCL_KHZ))
`define SCL_QTR_CYC     ((`SCL_QTR_NS + `CLK_NS - 1) / `CLK_NS)
`define WORDS           128
`define PAGE_BYTES      4
`define BYTE_DONE       4'h8
`define RW_READ         1'b1
`endif

/* inc/eeprom_pkg.sv */
// Purpose: state types shared by both link ends
// Assumes: nothing
// Notes:   one-hot codes
package eeprom_pkg;
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_ADDR  = 7'h02,
        S_AACK  = 7'h04,
        S_WDATA = 7'h08,
        S_WACK  = 7'h10,
        S_RDATA = 7'h20,
        S_RACK  = 7'h40
    } slv_state_t;
    typedef enum logic [4:0] {
        M_IDLE  = 5'h01,
        M_START = 5'h02,
        M_BIT   = 5'h04,
        M_STOP  = 5'h08,
        M_WAIT  = 5'h10
    } mst_state_t;
endpackage

/* inc/two_wire_if.sv */
// Purpose: clock line and shared open-drain data line
// Assumes: pull-up on data line
// Notes:   enables low while a party drives
interface two_wire_if;
    logic scl;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic mst_sda_o;
    logic mst_sda_oe_n;
    logic sda;
    // Wired-AND with pull-up
    assign sda = (dev_sda_oe_n | dev_sda_o) & (mst_sda_oe_n | mst_sda_o);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
    modport mst (output scl, input sda, output mst_sda_o, output mst_sda_oe_n);
endinterface

/* sim/two_wire_eeprom_slave_1k_properties.sv */
// Purpose: concurrent checks on the shared two-wire link between master and memory end
// Assumes: clean master clock line; one memory end on the link
// Notes:   bit counter restarts on every start or stop seen on the raw lines
module two_wire_eeprom_slave_1k_properties #(
    parameter int WR_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic mst_sda_o,
    input wire logic mst_sda_oe_n,
    input wire logic write_busy,
    input wire logic standby
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        scl_q;
    logic        sda_q;
    logic [3:0]  rise_cnt_q;
    logic [31:0] busy_cnt_q;
    wire         start_seen = scl_q & scl & sda_q & ~sda;
    wire         stop_seen  = scl_q & scl & ~sda_q & sda;
    wire         scl_rise   = ~scl_q & scl;
    wire         frame_edge = start_seen | stop_seen;
    wire [3:0]   rise_cnt_d = frame_edge ? 4'h0 :
                              (scl_rise && rise_cnt_q != 4'hf) ? rise_cnt_q + 4'h1 : rise_cnt_q;
    wire [31:0]  busy_cnt_d = write_busy ? busy_cnt_q + 32'h1 : 32'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            rise_cnt_q <= 4'h0;
            busy_cnt_q <= 32'h0;
        end else begin
            scl_q      <= scl;
            sda_q      <= sda;
            rise_cnt_q <= rise_cnt_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_open_drain; dev_sda_o == 1'b0 && mst_sda_o == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    property p_idle_release; standby |-> dev_sda_oe_n; endproperty
    a_idle_release: assert property (p_idle_release) else $error("idle end drives data");
    property p_busy_release; write_busy |-> dev_sda_oe_n; endproperty
    a_busy_release: assert property (p_busy_release) else $error("busy end drives data");
    property p_busy_quiet; write_busy |-> !standby; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("standby during write");
    // Slave may only move its data enable while the clock is low
    property p_dev_change; $changed(dev_sda_oe_n) |-> !scl; endproperty
    a_dev_change: assert property (p_dev_change) else $error("data moved, clock high");
    property p_busy_cause;
        $rose(write_busy) |-> scl && sda && $past(rise_cnt_q) == 4'h0;
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("write cycle without stop");
    property p_busy_len; $fell(write_busy) |-> busy_cnt_q == WR_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_busy_max; write_busy |-> busy_cnt_q < WR_CYCLES; endproperty
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
    property p_start_wake; (start_seen && !write_busy) |-> ##[1:12] !standby; endproperty
    a_start_wake: assert property (p_start_wake) else $error("start not seen");
    property p_stop_standby; stop_seen |-> ##[1:12] (standby || write_busy); endproperty
    a_stop_standby: assert property (p_stop_standby) else $error("no standby after stop");
    // Ninth rise after start is the address acknowledge
    property p_addr_ack;
        (scl_rise && rise_cnt_q == 4'h8 && !write_busy) |-> !sda && !dev_sda_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

    c_write: cover property ($rose(write_busy));
    c_write_end: cover property ($fell(write_busy));
    c_addr_ack: cover property (scl_rise && rise_cnt_q == 4'h8);
    c_standby: cover property ($rose(standby));
endmodule

/* sim/two_wire_eeprom_slave_1k_tb.sv */
// Purpose: drives the master command port and checks data through the memory end
// Assumes: shortened power-up, write and quarter-bit counts
// Notes:   reference memory only read where written earlier
module two_wire_eeprom_slave_1k_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int WR_CYC = 50;

    logic        clk        = 1'b0;
    logic        rst_n      = 1'b0;
    logic        cmd_valid  = 1'b0;
    logic        cmd_read   = 1'b0;
    logic [6:0]  cmd_addr   = 7'h00;
    logic [2:0]  cmd_len    = 3'h1;
    logic [31:0] cmd_wdata  = 32'h0;
    logic        cmd_ready;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        done;
    logic        nack;
    logic        write_busy;
    logic        standby;
    logic [7:0]  mem [128];
    logic [7:0]  rq [$];
    logic [7:0]  aq [$];
    int          num_errors = 0;
    int          n_compared = 0;
    int          nbit       = 0;
    logic        scl_q      = 1'b1;
    logic        sda_q      = 1'b1;
    logic [7:0]  sh         = 8'h00;

    always #12.5 clk = ~clk;

    two_wire_if bus ();

    eeprom_slave #(.WR_CYCLES(WR_CYC)) eeprom_slave_i (
        .clk        (clk),
        .rst_n      (rst_n),
        .bus        (bus),
        .write_busy (write_busy),
        .standby    (standby)
    );

    bus_master #(.QTR_CYC(20), .PUR_CYC(10), .PUW_CYC(20), .WAIT_CYC(60)) bus_master_i (
        .clk       (clk),
        .rst_n     (rst_n),
        .bus       (bus),
        .cmd_valid (cmd_valid),
        .cmd_ready (cmd_ready),
        .cmd_read  (cmd_read),
        .cmd_addr  (cmd_addr),
        .cmd_len   (cmd_len),
        .cmd_wdata (cmd_wdata),
        .rd_valid  (rd_valid),
        .rd_data   (rd_data),
        .done      (done),
        .nack      (nack)
    );

    two_wire_eeprom_slave_1k_properties #(
        .WR_CYCLES (WR_CYC)
    ) two_wire_eeprom_slave_1k_properties_i (
        .clk          (clk),
        .rst_n        (rst_n),
        .scl          (bus.scl),
        .sda          (bus.sda),
        .dev_sda_o    (bus.dev_sda_o),
        .dev_sda_oe_n (bus.dev_sda_oe_n),
        .mst_sda_o    (bus.mst_sda_o),
        .mst_sda_oe_n (bus.mst_sda_oe_n),
        .write_busy   (write_busy),
        .standby      (standby)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Entered and left at a falling edge; notes expectations before the command goes out
    task automatic do_cmd(input logic rd, input logic [6:0] a, input logic [2:0] len,
                          input logic [31:0] wd);
        int i;
        aq.push_back({a, rd});
        for (i = 0; i < len; i++) begin
            if (rd)
                rq.push_back(mem[7'(a + i)]);
            else
                mem[{a[6:2], 2'(a[1:0] + i)}] = wd[8*i +: 8];
        end
        cmd_valid = 1'b1;
        cmd_read  = rd;
        cmd_addr  = a;
        cmd_len   = len;
        cmd_wdata = wd;
        i = 0;
        while (cmd_ready !== 1'b1 && i < 2000) begin
            @(negedge clk);
            i++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 8000) begin
            @(negedge clk);
            i++;
        end
        chk("done", 8'h1, {7'h0, done});
        chk("nack", 8'h0, {7'h0, nack});
        if (rd)
            chk("standby", 8'h1, {7'h0, standby});
        else
            chk("write_busy", 8'h1, {7'h0, write_busy});
    endtask

    // Wire watcher: address byte goes out MSB first, then the slave pulls the ninth bit low
    always @(negedge clk) begin
        if (scl_q && bus.scl && sda_q && !bus.sda) begin
            nbit = 0;
        end else if (!scl_q && bus.scl) begin
            if (nbit < 8)
                sh = {sh[6:0], bus.sda};
            if (nbit == 8 && aq.size() > 0) begin
                chk("addr_byte", aq.pop_front(), sh);
                chk("addr_ack", 8'h0, {7'h0, bus.sda});
            end
            nbit++;
        end
        scl_q = bus.scl;
        sda_q = bus.sda;
        if (rd_valid === 1'b1) begin
            if (rq.size() > 0)
                chk("rd_data", rq.pop_front(), rd_data);
            else
                chk("rd_extra", 8'h0, 8'h1);
        end
    end

    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial begin
        int         k;
        logic [6:0] pa;
        logic [2:0] ln;
        k = $urandom(25);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        do_cmd(1'b0, 7'h00, 3'h4, $urandom());
        do_cmd(1'b0, 7'h7e, 3'h4, $urandom());
        do_cmd(1'b1, 7'h7e, 3'h4, 32'h0);
        do_cmd(1'b1, 7'h7c, 3'h1, 32'h0);
        do_cmd(1'b0, 7'h01, 3'h1, $urandom());
        do_cmd(1'b1, 7'h00, 3'h2, 32'h0);
        for (k = 0; k < 5; k++) begin
            pa = 7'($urandom());
            ln = 3'($urandom_range(1, 4));
            do_cmd(1'b0, pa, 3'h4, $urandom());
            do_cmd(1'b1, {pa[6:2], 2'($urandom_range(0, 4 - ln))}, ln, 32'h0);
        end
        repeat (100) @(negedge clk);
        chk("rd_left", 8'h0, 8'(rq.size()));
        final_report();
    end
endmodule
